// *** bench/port_sink.sv ***
// Image port receiver model that captures packet bytes and may stall
`timescale 1ns/1ps
module port_sink (
    // Clock
    input  wire logic       clk,
    // Stall control
    input  wire logic       stall_en,
    // Image port
    input  wire logic       port_valid,
    input  wire logic [7:0] port_data,
    output logic            port_ready
);
    // ==========================================================
    // Receive queue and stall pattern
    logic [7:0] rx_q[$];
    logic [1:0] phase_ff;

    initial begin
        port_ready = 1'b0;
        phase_ff   = 2'h0;
    end

    // Ready one cycle in three while stalling, so the buffer fills
    always @(negedge clk) begin
        phase_ff   <= (phase_ff == 2'h2) ? 2'h0 : phase_ff + 2'h1;
        port_ready <= !stall_en || (phase_ff == 2'h0);
    end

    always @(posedge clk) begin
        if (port_valid && port_ready) begin
            rx_q.push_back(port_data);
        end
    end
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the blanking-interval packet framer
`timescale 1ns/1ps
module tb;
    // ==========================================================
    // Signals
    logic       clk;
    logic       rst_n;
    logic       line_start;
    logic       odd_even;
    logic       cfg_field_inv;
    logic       cfg_vblank_bit;
    logic       slc_valid;
    logic       slc_last;
    logic       stall_en;
    logic [7:0] hdr_type;
    logic [7:0] hdr_line;
    logic [7:0] cfg_sdid;
    logic [7:0] slc_data;
    logic       slc_ready;
    logic       port_valid;
    logic       port_ready;
    logic       framer_busy;
    logic [7:0] port_data;
    int         mismatches;
    int         compares;

    vbi_slicer_packet_framer dut_u (
        .CLK(clk), .RST_N(rst_n), .LINE_START(line_start), .ODD_EVEN(odd_even),
        .HEADER_TYPE_BYTE(hdr_type), .HEADER_LINE_BYTE(hdr_line),
        .CFG_FIELD_INV(cfg_field_inv), .CFG_VBLANK_BIT(cfg_vblank_bit), .CFG_SDID(cfg_sdid),
        .SLC_VALID(slc_valid), .SLC_DATA(slc_data), .SLC_LAST(slc_last), .SLC_READY(slc_ready),
        .PORT_VALID(port_valid), .PORT_DATA(port_data), .PORT_READY(port_ready),
        .FRAMER_BUSY(framer_busy)
    );

    port_sink sink_u (
        .clk(clk), .stall_en(stall_en), .port_valid(port_valid),
        .port_data(port_data), .port_ready(port_ready)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ==========================================================
    // Shared helpers
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
        compares++;
    endtask

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    function automatic logic [7:0] code(input logic f, input logic v, input logic h);
        code = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
    endfunction

    // One line: start, feed n payload bytes, collect and judge 56 bytes
    task automatic send_line(input int n, input logic odd, input logic inv, input logic vb,
                             input logic [7:0] sdid, input logic [7:0] typ,
                             input logic [7:0] ln, input logic use_last, input logic retrig);
        logic [7:0] pay[42];
        logic [7:0] sum;
        logic [7:0] got;
        logic       took;
        int         i;
        int         p;
        int         guard;
        int         base;
        base = sink_u.rx_q.size();
        sum  = typ + ln;
        for (i = 0; i < 42; i++) begin
            pay[i] = 8'(i * 7 + 3) ^ ln;
        end
        @(negedge clk);
        odd_even       = odd;
        cfg_field_inv  = inv;
        cfg_vblank_bit = vb;
        cfg_sdid       = sdid;
        hdr_type       = typ;
        hdr_line       = ln;
        line_start     = 1'b1;
        @(negedge clk);
        check("busy after start", {7'h00, framer_busy}, 8'h01);
        line_start = 1'b0;
        i          = 0;
        guard      = 0;
        slc_valid  = 1'b1;
        slc_data   = pay[0];
        slc_last   = use_last && (n == 1);
        while (i < n && guard < 2000) begin
            took = slc_ready;
            @(negedge clk);
            guard++;
            line_start = retrig && (guard == 3);
            if (took) begin
                sum = sum + pay[i];
                i++;
            end
            if (i < n) begin
                slc_data = pay[i];
                slc_last = use_last && (i == n - 1);
            end else begin
                slc_valid = 1'b0;
                slc_last  = 1'b0;
            end
        end
        line_start = 1'b0;
        if (i < n) begin
            mismatches++;
            test_done();
        end
        guard      = 0;
        while (sink_u.rx_q.size() < base + 56 && guard < 5000) begin
            @(negedge clk);
            guard++;
        end
        if (guard >= 5000) begin
            mismatches++;
            test_done();
        end
        repeat (100) @(negedge clk);
        check("busy at end", {7'h00, framer_busy}, 8'h00);
        check("packet length", 8'(sink_u.rx_q.size() - base), 8'd56);
        for (p = 0; p < 56; p++) begin
            got = sink_u.rx_q[base + p];
            if (p == 3 || p == 55) check("timing code", got, code(odd ^ inv, vb, p == 55));
            else if (p == 0 || p == 52) check("preamble", got, 8'hFF);
            else if (p < 3 || p > 52) check("preamble", got, 8'h00);
            else if (p == 4) check("header sdid", got, sdid);
            else if (p == 5) check("dword count", got, 8'h0B);
            else if (p == 6) check("header type", got, typ);
            else if (p == 7) check("header line", got, ln);
            else if (p < 8 + n) check("payload", got, pay[p - 8]);
            else if (p < 50) check("stuff", got, 8'hA0);
            else if (p == 50) check("byte count", got, 8'(n + 2));
            else check("checksum", got, sum);
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic test_char_broadcast();
        stall_en = 1'b1;
        send_line(35, 1'b0, 1'b0, 1'b1, 8'h5A, 8'h2C, 8'h15, 1'b1, 1'b0);
        $display("test char_broadcast done");
    endtask

    task automatic test_full_payload();
        stall_en = 1'b0;
        send_line(42, 1'b1, 1'b0, 1'b0, 8'hC3, 8'hF7, 8'h0E, 1'b0, 1'b0);
        send_line(42, 1'b1, 1'b1, 1'b1, 8'h3C, 8'h81, 8'h10, 1'b1, 1'b0);
        $display("test full_payload done");
    endtask

    task automatic test_single_refused_start();
        stall_en = 1'b1;
        send_line(1, 1'b1, 1'b0, 1'b1, 8'h00, 8'hFF, 8'hFF, 1'b1, 1'b1);
        $display("test single_refused_start done");
    endtask

    task automatic test_back_to_back();
        stall_en = 1'b0;
        send_line(20, 1'b0, 1'b1, 1'b0, 8'h99, 8'h42, 8'h17, 1'b1, 1'b0);
        send_line(21, 1'b0, 1'b1, 1'b1, 8'h66, 8'h07, 8'h18, 1'b1, 1'b0);
        $display("test back_to_back done");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        mismatches     = 0;
        compares       = 0;
        rst_n          = 1'b0;
        line_start     = 1'b0;
        odd_even       = 1'b0;
        cfg_field_inv  = 1'b0;
        cfg_vblank_bit = 1'b0;
        cfg_sdid       = 8'h00;
        hdr_type       = 8'h00;
        hdr_line       = 8'h00;
        slc_valid      = 1'b0;
        slc_last       = 1'b0;
        slc_data       = 8'h00;
        stall_en       = 1'b0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        test_char_broadcast();
        test_full_payload();
        test_single_refused_start();
        test_back_to_back();
        test_done();
    end
endmodule

// *** src/byte_buffer.sv ***
// Two-entry byte buffer with registered outputs
`timescale 1ns/1ps
module byte_buffer (
    // Clock and reset
    input  wire logic CLK,
    input  wire logic RST_N,
    // Streams
    stream_if.snk     in_s,
    stream_if.src     out_s
);

    logic       out_v_ff;
    logic [7:0] out_d_ff;
    logic       skid_v_ff;
    logic [7:0] skid_d_ff;
    logic       in_fire;

    assign in_s.ready  = !skid_v_ff;
    assign in_fire     = in_s.valid && !skid_v_ff;
    assign out_s.valid = out_v_ff;
    assign out_s.data  = out_d_ff;

    // ==========================================================
    // Head and skid entries
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            out_v_ff  <= 1'b0;
            out_d_ff  <= 8'h00;
            skid_v_ff <= 1'b0;
            skid_d_ff <= 8'h00;
        end else if (!out_v_ff || out_s.ready) begin
            if (skid_v_ff) begin
                out_v_ff  <= 1'b1;
                out_d_ff  <= skid_d_ff;
                skid_v_ff <= 1'b0;
            end else begin
                out_v_ff <= in_fire;
                if (in_fire) begin
                    out_d_ff <= in_s.data;
                end
            end
        end else if (in_fire) begin
            skid_v_ff <= 1'b1;
            skid_d_ff <= in_s.data;
        end
    end

    // ==========================================================
    // Checks
    chk_stall_holds: assert property (@(posedge CLK) disable iff (!RST_N)
        out_v_ff && !out_s.ready |=> out_v_ff && $stable(out_d_ff))
        else $error("output byte changed while stalled");

endmodule

// *** src/stream_if.sv ***
// Byte stream carrier between framer and output buffer, and between output buffer and image port
`timescale 1ns/1ps
interface stream_if;
    logic       valid;
    logic       ready;
    logic [7:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// *** src/vbi_pkg.sv ***
// Constants, types and code helpers for the blanking-interval packet framer
package vbi_pkg;

    // ==========================================================
    // Packet layout (byte positions from the first preamble byte)
    localparam logic [5:0] PKT_LEN      = 6'd56;
    localparam logic [5:0] POS_SAV_CODE = 6'd3;
    localparam logic [5:0] POS_SDID     = 6'd4;
    localparam logic [5:0] POS_DWORD    = 6'd5;
    localparam logic [5:0] POS_TYPE     = 6'd6;
    localparam logic [5:0] POS_LINE     = 6'd7;
    localparam logic [5:0] POS_DATA     = 6'd8;
    localparam logic [5:0] POS_BCNT     = 6'd50;
    localparam logic [5:0] POS_CSUM     = 6'd51;
    localparam logic [5:0] POS_EAV      = 6'd52;
    localparam logic [5:0] PAY_MAX      = 6'd42;

    // ==========================================================
    // Fixed byte values
    localparam logic [7:0] PRE_FIRST    = 8'hFF;
    localparam logic [7:0] PRE_ZERO     = 8'h00;
    localparam logic [7:0] DWORD_CNT    = 8'h0B;
    localparam logic [7:0] STUFF_BYTE   = 8'hA0;
    localparam logic [7:0] CNT_RESET    = 8'h00;

    // ==========================================================
    // Framer states
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_SAV   = 6'h02,
        ST_HDR   = 6'h04,
        ST_DATA  = 6'h08,
        ST_STUFF = 6'h10,
        ST_TAIL  = 6'h20
    } state_e;

    // Timing code byte: 1 F V H P3 P2 P1 P0
    function automatic logic [7:0] code_byte(input logic f, input logic v, input logic h);
        code_byte = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
    endfunction

    // Preamble byte for offset 0..2 inside a timing sequence
    function automatic logic [7:0] pre_byte(input logic [5:0] rel);
        pre_byte = (rel == 6'd0) ? PRE_FIRST : PRE_ZERO;
    endfunction

endpackage

// *** src/vbi_slicer_packet_framer.sv ***
// Framer that packs sliced blanking-interval data into fixed image port packets
// Summary of operation
// - Sliced data leaves as bytes inside the image port video stream.
// - Each packet is exactly 56 bytes, timing codes included.
// - Start and end codes follow the field identity and configured settings.
// - Four header bytes follow the start code, with type and line bytes.
// - Byte count and checksum directly precede the end code.
// - Positions between payload and byte count are filled with A0.
// - Character-broadcast lines (35 bytes) are framed like any other standard.
// - Payload begins right after the header; no spurious bytes inserted.
`timescale 1ns/1ps
module vbi_slicer_packet_framer import vbi_pkg::*; (
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RST_N,
    // Line control from the slicer
    input  wire logic       LINE_START,
    input  wire logic       ODD_EVEN,
    input  wire logic [7:0] HEADER_TYPE_BYTE,
    input  wire logic [7:0] HEADER_LINE_BYTE,
    // Static configuration
    input  wire logic       CFG_FIELD_INV,
    input  wire logic       CFG_VBLANK_BIT,
    input  wire logic [7:0] CFG_SDID,
    // Sliced payload
    input  wire logic       SLC_VALID,
    input  wire logic [7:0] SLC_DATA,
    input  wire logic       SLC_LAST,
    output logic            SLC_READY,
    // Image port stream
    output logic            PORT_VALID,
    output logic [7:0]      PORT_DATA,
    input  wire logic       PORT_READY,
    // Status
    output logic            FRAMER_BUSY
);

    state_e     state_ff;
    state_e     nxt_state;
    logic [5:0] pos_ff;
    logic [5:0] pay_cnt_ff;
    logic       pay_done_ff;
    logic       hold_v_ff;
    logic [7:0] hold_ff;
    logic       slc_rdy_ff;
    logic       field_ff;
    logic       vbit_ff;
    logic [7:0] type_ff;
    logic [7:0] line_ff;
    logic [7:0] sdid_ff;
    logic [7:0] bcnt_ff;
    logic [7:0] sum_ff;
    logic       busy_ff;
    logic [7:0] byte_out;
    logic       byte_avail;
    logic       push;
    logic       slc_take;
    logic       counted;
    logic [5:0] eav_rel;

    stream_if fr_if ();
    stream_if pt_if ();

    // ==========================================================
    // Output buffer
    byte_buffer u_buf (
        .CLK   (CLK),
        .RST_N (RST_N),
        .in_s  (fr_if),
        .out_s (pt_if)
    );

    assign fr_if.valid = byte_avail;
    assign fr_if.data  = byte_out;
    assign pt_if.ready = PORT_READY;
    assign PORT_VALID  = pt_if.valid;
    assign PORT_DATA   = pt_if.data;
    assign SLC_READY   = slc_rdy_ff;
    assign FRAMER_BUSY = busy_ff;

    assign push     = byte_avail && fr_if.ready;
    assign slc_take = SLC_VALID && slc_rdy_ff;
    assign eav_rel  = pos_ff - POS_EAV;
    assign counted  = push && ((state_ff == ST_HDR && pos_ff >= POS_TYPE)
                      || state_ff == ST_DATA);

    // ==========================================================
    // Byte selection
    always_comb begin
        byte_avail = 1'b1;
        byte_out   = PRE_ZERO;
        case (state_ff)
            ST_SAV: begin
                if (pos_ff == POS_SAV_CODE) begin
                    byte_out = code_byte(field_ff, vbit_ff, 1'b0);
                end else begin
                    byte_out = pre_byte(pos_ff);
                end
            end
            ST_HDR: begin
                case (pos_ff)
                    POS_SDID: byte_out = sdid_ff;
                    POS_DWORD: byte_out = DWORD_CNT;
                    POS_TYPE: byte_out = type_ff;
                    default:  byte_out = line_ff;
                endcase
            end
            ST_DATA: begin
                byte_avail = hold_v_ff;
                byte_out   = hold_ff;
            end
            ST_STUFF: byte_out = STUFF_BYTE;
            ST_TAIL: begin
                if (pos_ff == POS_BCNT) begin
                    byte_out = bcnt_ff;
                end else if (pos_ff == POS_CSUM) begin
                    byte_out = sum_ff;
                end else if (eav_rel == 6'd3) begin
                    byte_out = code_byte(field_ff, vbit_ff, 1'b1);
                end else begin
                    byte_out = pre_byte(eav_rel);
                end
            end
            default: byte_avail = 1'b0;
        endcase
    end

    // ==========================================================
    // Sequence control
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (LINE_START) begin
                    nxt_state = ST_SAV;
                end
            end
            ST_SAV: begin
                if (push && pos_ff == POS_SAV_CODE) begin
                    nxt_state = ST_HDR;
                end
            end
            ST_HDR: begin
                if (push && pos_ff == POS_LINE) begin
                    nxt_state = ST_DATA;
                end
            end
            ST_DATA: begin
                if (pay_done_ff && !hold_v_ff) begin
                    nxt_state = (pos_ff == POS_BCNT) ? ST_TAIL : ST_STUFF;
                end
            end
            ST_STUFF: begin
                if (push && pos_ff == POS_BCNT - 6'd1) begin
                    nxt_state = ST_TAIL;
                end
            end
            ST_TAIL: begin
                if (push && pos_ff == PKT_LEN - 6'd1) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_ff <= ST_IDLE;
            busy_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            busy_ff  <= (nxt_state != ST_IDLE);
        end
    end

    // Byte position inside the packet
    always_ff @(posedge CLK) begin
        if (!RST_N || state_ff == ST_IDLE) begin
            pos_ff <= 6'd0;
        end else if (push && pos_ff == PKT_LEN - 6'd1) begin
            pos_ff <= 6'd0;
        end else if (push) begin
            pos_ff <= pos_ff + 6'd1;
        end
    end

    // Line attributes captured at line start
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            field_ff <= 1'b0;
            vbit_ff  <= 1'b0;
            type_ff  <= 8'h00;
            line_ff  <= 8'h00;
            sdid_ff  <= 8'h00;
        end else if (state_ff == ST_IDLE && LINE_START) begin
            field_ff <= ODD_EVEN ^ CFG_FIELD_INV;
            vbit_ff  <= CFG_VBLANK_BIT;
            type_ff  <= HEADER_TYPE_BYTE;
            line_ff  <= HEADER_LINE_BYTE;
            sdid_ff  <= CFG_SDID;
        end
    end

    // ==========================================================
    // Payload intake, one byte held at a time
    always_ff @(posedge CLK) begin
        if (!RST_N || state_ff == ST_IDLE) begin
            pay_cnt_ff  <= 6'd0;
            pay_done_ff <= 1'b0;
        end else if (slc_take) begin
            pay_cnt_ff <= pay_cnt_ff + 6'd1;
            if (SLC_LAST || pay_cnt_ff == PAY_MAX - 6'd1) begin
                pay_done_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            hold_v_ff <= 1'b0;
            hold_ff   <= 8'h00;
        end else if (slc_take) begin
            hold_v_ff <= 1'b1;
            hold_ff   <= SLC_DATA;
        end else if (push && state_ff == ST_DATA) begin
            hold_v_ff <= 1'b0;
        end
    end

    // Ready drops after each take so the holding byte is never overrun
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            slc_rdy_ff <= 1'b0;
        end else begin
            slc_rdy_ff <= (state_ff == ST_DATA) && !pay_done_ff
                          && !hold_v_ff && !slc_take;
        end
    end

    // ==========================================================
    // Byte count and checksum
    always_ff @(posedge CLK) begin
        if (!RST_N || state_ff == ST_IDLE) begin
            bcnt_ff <= CNT_RESET;
            sum_ff  <= CNT_RESET;
        end else if (counted) begin
            bcnt_ff <= bcnt_ff + 8'h01;
            sum_ff  <= sum_ff + byte_out;
        end
    end

    // ==========================================================
    // Checks
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);

    chk_packet_length: assert property (
        push && pos_ff == PKT_LEN - 6'd1 |=> state_ff == ST_IDLE && pos_ff == 6'd0)
        else $error("packet did not close after 56 bytes");

    chk_pos_bound: assert property (pos_ff < PKT_LEN)
        else $error("byte position beyond packet end");

    chk_sav_code: assert property (
        push && state_ff == ST_SAV && pos_ff == POS_SAV_CODE
        |-> byte_out == code_byte(field_ff, vbit_ff, 1'b0))
        else $error("start code does not match field and setting");

    chk_eav_code: assert property (
        push && pos_ff == PKT_LEN - 6'd1
        |-> state_ff == ST_TAIL && byte_out == code_byte(field_ff, vbit_ff, 1'b1))
        else $error("end code wrong or misplaced");

    chk_header_dword: assert property (
        push && pos_ff == POS_DWORD |-> state_ff == ST_HDR && byte_out == DWORD_CNT)
        else $error("header dword count byte wrong");

    chk_stuff_value: assert property (
        push && pos_ff >= POS_DATA && pos_ff < POS_BCNT && state_ff != ST_DATA
        |-> byte_out == STUFF_BYTE)
        else $error("padding byte not A0");

    chk_no_gap: assert property (
        push && state_ff == ST_DATA |-> $past(hold_v_ff) || $past(slc_take))
        else $error("payload byte emitted without slicer byte");

    chk_take_order: assert property (
        slc_take |=> !slc_rdy_ff && hold_v_ff && hold_ff == $past(SLC_DATA))
        else $error("payload byte not held after take");

    chk_count_match: assert property (
        push && pos_ff == POS_BCNT |-> bcnt_ff == {2'b00, pay_cnt_ff} + 8'h02)
        else $error("byte count differs from emitted bytes");

    chk_pay_cap: assert property (pay_cnt_ff <= PAY_MAX)
        else $error("payload exceeds packet room");

endmodule
